// ### rtl/dhi_map.vh
// Constants for the display host interface controller.
`ifndef DHI_MAP_VH
`define DHI_MAP_VH
// Bus styles selected by the mode input.
`define DHI_MODE_PAR_SEP 2'h0
`define DHI_MODE_PAR_EN 2'h1
`define DHI_MODE_SER3 2'h2
`define DHI_MODE_SER4 2'h3
// Clock period and printed times in ns.
`define DHI_CLK_NS 10
`define DHI_PW_WR_NS 60
`define DHI_PW_RD_NS 120
`define DHI_PW_HI_NS 60
`define DHI_SETUP_NS 40
`define DHI_ACC_NS 140
`define DHI_SCK_LO_NS 20
`define DHI_SCK_HI_NS 200
// Cycle counts, least times rounded up.
`define DHI_CYC(ns) (((ns) + `DHI_CLK_NS - 1) / `DHI_CLK_NS)
`define DHI_PW_WR_CYC `DHI_CYC(`DHI_PW_WR_NS)
`define DHI_PW_RD_CYC `DHI_CYC(`DHI_PW_RD_NS)
`define DHI_PW_HI_CYC `DHI_CYC(`DHI_PW_HI_NS)
`define DHI_SETUP_CYC `DHI_CYC(`DHI_SETUP_NS)
`define DHI_ACC_CYC `DHI_CYC(`DHI_ACC_NS)
`define DHI_SCK_LO_CYC `DHI_CYC(`DHI_SCK_LO_NS)
`define DHI_SCK_HI_CYC `DHI_CYC(`DHI_SCK_HI_NS)
`endif

// ### rtl/dhi_timer.v
// Down counter that times each phase of a bus transfer.
`timescale 1ns/1ns
`default_nettype none
module dhi_timer (
   // Clock and reset.
   input wire clk,
   input wire srst,
   // Load a phase length; done pulses when it expires.
   input wire load,
   input wire [7:0] count,
   output reg done
);
   reg [7:0] remain;
   reg busy;
   always @(posedge clk) begin
      if (srst) begin
         remain <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         remain <= count;
         busy <= 1'b1;
         done <= 1'b0;
      end else if (busy && remain <= 8'h01) begin
         busy <= 1'b0;
         done <= 1'b1;
      end else begin
         remain <= remain - 8'h01;
         done <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### rtl/dhi_host.v
// Host controller driving a display module over parallel or serial pins.
`timescale 1ns/1ns
`default_nettype none
`include "dhi_map.vh"
module dhi_host (
   // Clock and reset.
   input wire clk,
   input wire srst,
   // Configuration.
   input wire [1:0] mode,
   input wire csLatch,
   // Request side.
   input wire reqValid,
   input wire reqRead,
   input wire reqData,
   input wire [7:0] reqByte,
   input wire newAddress,
   output reg reqReady,
   output reg rspValid,
   output reg [7:0] rspByte,
   output reg rspError,
   // Pins to the module.
   output reg chipSelectN,
   output reg cmdDataSelect,
   output reg strobeA,
   output reg strobeB,
   output reg [7:0] busOut,
   output reg busOe,
   input wire [7:0] busIn,
   output reg hard_reset_n
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SETUP = 3'h1;
   localparam ST_ACTIVE = 3'h2;
   localparam ST_RECOVER = 3'h3;
   localparam ST_SHIFT_LO = 3'h4;
   localparam ST_SHIFT_HI = 3'h5;
   localparam [31:0] SETUP_CYC = `DHI_SETUP_CYC;
   localparam [31:0] PW_WR_CYC = `DHI_PW_WR_CYC;
   localparam [31:0] PW_RD_CYC = `DHI_PW_RD_CYC;
   localparam [31:0] PW_HI_CYC = `DHI_PW_HI_CYC;
   localparam [31:0] SCK_LO_CYC = `DHI_SCK_LO_CYC;
   localparam [31:0] SCK_HI_CYC = `DHI_SCK_HI_CYC;
   reg [2:0] state;
   reg isRead;
   reg isDummy;
   reg needDummy;
   reg [7:0] shiftReg;
   reg [2:0] bitCount;
   reg tLoad;
   reg [7:0] tCount;
   wire tDone;
   wire serialMode = mode[1];
   wire enMode = (mode == `DHI_MODE_PAR_EN);
   dhi_timer phaseTimer (
      .clk(clk),
      .srst(srst),
      .load(tLoad),
      .count(tCount),
      .done(tDone)
   );
   // ----------------------------------------
   // Transfer sequencer.
   // ----------------------------------------
   always @(posedge clk) begin
      tLoad <= 1'b0;
      rspValid <= 1'b0;
      if (srst) begin
         state <= ST_IDLE;
         isRead <= 1'b0;
         isDummy <= 1'b0;
         needDummy <= 1'b1;
         shiftReg <= 8'h00;
         bitCount <= 3'h0;
         tCount <= 8'h00;
         reqReady <= 1'b0;
         rspByte <= 8'h00;
         rspError <= 1'b0;
         chipSelectN <= 1'b1;
         cmdDataSelect <= 1'b0;
         strobeA <= 1'b1;
         strobeB <= 1'b1;
         busOut <= 8'h00;
         busOe <= 1'b0;
         hard_reset_n <= 1'b0;
      end else begin
         hard_reset_n <= 1'b1;
         if (newAddress) begin
            needDummy <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               reqReady <= 1'b1;
               // Idle strobe levels per bus style.
               strobeA <= ~enMode & ~serialMode;
               strobeB <= ~serialMode;
               if (reqValid && reqReady) begin
                  reqReady <= 1'b0;
                  if (serialMode && reqRead) begin
                     rspValid <= 1'b1;
                     rspError <= 1'b1;
                     rspByte <= 8'h00;
                  end else begin
                     rspError <= 1'b0;
                     isRead <= reqRead;
                     isDummy <= reqRead & reqData & (needDummy | newAddress);
                     cmdDataSelect <= serialMode && mode == `DHI_MODE_SER3 ? 1'b0 : reqData;
                     shiftReg <= reqByte;
                     busOut <= reqByte;
                     busOe <= ~reqRead & ~serialMode;
                     if (enMode) begin
                        strobeB <= reqRead;
                     end
                     chipSelectN <= 1'b0;
                     bitCount <= 3'h7;
                     tCount <= SETUP_CYC[7:0];
                     tLoad <= 1'b1;
                     state <= ST_SETUP;
                  end
               end
            end
            ST_SETUP: begin
               if (tDone) begin
                  tLoad <= 1'b1;
                  if (serialMode) begin
                     strobeA <= 1'b0;
                     strobeB <= shiftReg[7];
                     tCount <= SCK_LO_CYC[7:0];
                     state <= ST_SHIFT_LO;
                  end else begin
                     tCount <= isRead ? PW_RD_CYC[7:0] : PW_WR_CYC[7:0];
                     if (enMode) begin
                        strobeA <= 1'b1;
                     end else if (!csLatch) begin
                        if (isRead) strobeA <= 1'b0;
                        else strobeB <= 1'b0;
                     end else begin
                        strobeA <= ~isRead;
                        strobeB <= isRead;
                     end
                     state <= ST_ACTIVE;
                  end
               end
            end
            ST_ACTIVE: begin
               if (tDone) begin
                  if (enMode) strobeA <= 1'b0;
                  else if (!csLatch) begin
                     strobeA <= 1'b1;
                     strobeB <= 1'b1;
                  end
                  chipSelectN <= 1'b1;
                  if (isRead && !isDummy) begin
                     rspByte <= busIn;
                  end
                  tCount <= PW_HI_CYC[7:0];
                  tLoad <= 1'b1;
                  state <= ST_RECOVER;
               end
            end
            ST_SHIFT_LO: begin
               if (tDone) begin
                  strobeA <= 1'b1;
                  tCount <= SCK_HI_CYC[7:0];
                  tLoad <= 1'b1;
                  state <= ST_SHIFT_HI;
               end
            end
            ST_SHIFT_HI: begin
               if (tDone) begin
                  tLoad <= 1'b1;
                  if (bitCount == 3'h0) begin
                     chipSelectN <= 1'b1;
                     tCount <= PW_HI_CYC[7:0];
                     state <= ST_RECOVER;
                  end else begin
                     strobeA <= 1'b0;
                     strobeB <= shiftReg[6];
                     shiftReg <= {shiftReg[6:0], 1'b0};
                     bitCount <= bitCount - 3'h1;
                     tCount <= SCK_LO_CYC[7:0];
                     state <= ST_SHIFT_LO;
                  end
               end
            end
            ST_RECOVER: begin
               busOe <= 1'b0;
               if (tDone) begin
                  if (isDummy) begin
                     // Dummy result discarded; repeat as the real read.
                     isDummy <= 1'b0;
                     // An address change in the same cycle must win over the clear.
                     if (!newAddress) begin
                        needDummy <= 1'b0;
                     end
                     chipSelectN <= 1'b0;
                     if (enMode) strobeB <= 1'b1;
                     tCount <= SETUP_CYC[7:0];
                     tLoad <= 1'b1;
                     state <= ST_SETUP;
                  end else begin
                     if (isRead && cmdDataSelect && !newAddress) begin
                        needDummy <= 1'b0;
                     end
                     rspValid <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### verif/dhi_host_sva.sv
// Pin-level checks on the display host controller.
`timescale 1ns/1ns
`default_nettype none
module dhi_host_sva (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Request side.
   input wire logic [1:0] mode,
   input wire logic csLatch,
   input wire logic reqValid,
   input wire logic reqRead,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire logic rspError,
   // Pins.
   input wire logic chipSelectN,
   input wire logic cmdDataSelect,
   input wire logic strobeA,
   input wire logic strobeB,
   input wire logic [7:0] busOut,
   input wire logic busOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence take_s; reqValid && reqReady; endsequence
   sequence serRd_s; take_s ##0 (reqRead && mode[1]); endsequence
   // Chip select low in the previous cycle keeps idle pins left over from a mode switch out of the checks.
   property eFall_p;
      $fell(strobeA) && mode == 2'h1 && !$past(chipSelectN) |-> $stable(busOut) && $stable(strobeB) && $stable(cmdDataSelect);
   endproperty
   AST_SER_REFUSE: assert property (serRd_s |=> rspValid && rspError && chipSelectN)
      else $error("serial read not refused");
   AST_DONE: assert property (take_s |-> ##[1:400] rspValid)
      else $error("transfer never ended");
   AST_OE_DIR: assert property (busOe |-> !mode[1] && (mode == 2'h1 ? !strobeB : strobeA))
      else $error("bus driven outside a write");
   AST_E_CS: assert property (!$past(srst) && mode == 2'h1 && $stable(mode) && strobeA |-> !chipSelectN)
      else $error("enable without chip select");
   AST_E_FALL: assert property (eFall_p)
      else $error("pins moved at enable fall");
   AST_STRB_CS: assert property (mode == 2'h0 && !csLatch && $stable(mode) && !(strobeA && strobeB) |-> !chipSelectN)
      else $error("strobe without chip select");
   AST_CS_LATCH: assert property (mode == 2'h0 && csLatch && $rose(chipSelectN) |-> !$past(strobeA && strobeB))
      else $error("no strobe at chip select rise");
   AST_SER_SHIFT: assert property (mode[1] && !chipSelectN && $rose(strobeA) |-> $stable(strobeB))
      else $error("serial data moved at clock rise");
endmodule
`default_nettype wire

// ### verif/dhi_dev_model.sv
// Behavioural display module on the far side of the host pins.
`timescale 1ns/1ns
`default_nettype none
module dhi_dev_model #(
   parameter logic [7:0] STATUS = 8'h5a,
   parameter logic [7:0] BASE = 8'h40
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Pins from the host.
   input wire logic [1:0] mode,
   input wire logic chipSelectN,
   input wire logic cmdDataSelect,
   input wire logic strobeA,
   input wire logic strobeB,
   input wire logic [7:0] busOut,
   input wire logic busOe,
   // Bus level and last captured write.
   output logic [7:0] busIn,
   output logic [8:0] got
);
   logic pa, pb, pcs, pcd, rdg, ev, rd;
   logic [7:0] pbus, pipe, ptr, sh, last;
   logic [2:0] n;
   assign rdg = !chipSelectN && (mode == 2'h0 ? !strobeA : mode == 2'h1 && strobeB);
   // A released bus shows the inverse of its last value, so a stale copy never passes.
   assign busIn = busOe ? busOut : rdg ? (cmdDataSelect ? pipe : STATUS) : ~last;
   assign ev = !pcs && (mode == 2'h0 ? (!pb && (strobeB || chipSelectN)) || (!pa && (strobeA || chipSelectN))
      : mode == 2'h1 && pa && !strobeA);
   assign rd = mode == 2'h0 ? !pa : pb;
   always @(posedge clk) begin
      {pa, pb, pcs, pcd, pbus} <= {strobeA, strobeB, chipSelectN, cmdDataSelect, busOut};
      if (rdg) begin
         last <= busIn;
      end
      if (srst) begin
         {ptr, pipe, n, got, last} <= {8'h00, 8'hee, 3'h0, 9'h000, 8'h00};
      end else if (ev && !rd) begin
         got <= {pcd, pbus};
         if (!pcd) begin
            {ptr, pipe} <= {8'h00, 8'hee};
         end
      end else if (ev && pcd) begin
         pipe <= BASE + ptr;
         ptr <= ptr + 8'h01;
      end else if (mode[1] && !chipSelectN && !pa && strobeA) begin
         sh <= {sh[6:0], strobeB};
         n <= n + 3'h1;
         if (n == 3'h7) begin
            got <= {mode[0] && cmdDataSelect, sh[6:0], strobeB};
         end
      end else if (chipSelectN) begin
         n <= 3'h0;
      end
   end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the display host controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 1'b0, srst = 1'b1, csLatch = 1'b0, reqValid = 1'b0, reqRead = 1'b0, reqData = 1'b0, newAddress = 1'b0;
   logic [1:0] mode = 2'h1;
   logic [7:0] reqByte = 8'h00;
   wire reqReady, rspValid, rspError, chipSelectN, cmdDataSelect, strobeA, strobeB, busOe, hard_reset_n;
   wire [7:0] rspByte, busOut, busIn;
   wire [8:0] got;
   int mismatches = 0, n_checks = 0, cyc = 0;
   // Row: mode, read, data, byte, then the expected read byte or captured write.
   logic [20:0] rows [7] = '{21'h094aa5, 21'h0a793c, 21'h0387c3, 21'h0c005a, 21'h04005a, 21'h1b2d96, 21'h130281};
   always #5 clk = ~clk;
   dhi_host dut (.clk, .srst, .mode, .csLatch, .reqValid, .reqRead, .reqData, .reqByte, .newAddress, .reqReady,
      .rspValid, .rspByte, .rspError, .chipSelectN, .cmdDataSelect, .strobeA, .strobeB, .busOut, .busOe, .busIn,
      .hard_reset_n);
   dhi_dev_model model (.clk, .srst, .mode, .chipSelectN, .cmdDataSelect, .strobeA, .strobeB, .busOut, .busOe,
      .busIn, .got);
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic stop_test;
      if (mismatches == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Outputs are read one unit after the edge, clear of the design's own updates.
   task automatic xfer(input logic [1:0] m, input logic r, input logic d, input logic [7:0] b);
      @(posedge clk);
      {mode, reqRead, reqData, reqByte, reqValid} <= {m, r, d, b, 1'b1};
      #1;
      while (reqReady !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      reqValid <= 1'b0;
      #1;
      while (rspValid !== 1'b1) begin
         @(posedge clk);
         #1;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         stop_test;
      end
   end
   // ---------------------------------------------
   // Table cases, then directed cases.
   // ---------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      chk({7'h00, hard_reset_n, chipSelectN}, 9'h001);
      srst <= 1'b0;
      foreach (rows[i]) begin
         xfer(rows[i][20:19], rows[i][18], rows[i][17], rows[i][16:9]);
         chk(rows[i][18] ? {1'b0, rspByte} : got, rows[i][8:0]);
      end
      @(posedge clk) csLatch <= 1'b1;
      xfer(2'h0, 1'b0, 1'b1, 8'h77);
      chk(got, 9'h177);
      xfer(2'h0, 1'b1, 1'b0, 8'h00);
      chk({1'b0, rspByte}, 9'h05a);
      @(posedge clk) csLatch <= 1'b0;
      xfer(2'h1, 1'b0, 1'b0, 8'h15);
      @(posedge clk) newAddress <= 1'b1;
      @(posedge clk) newAddress <= 1'b0;
      xfer(2'h1, 1'b1, 1'b1, 8'h00);
      chk({1'b0, rspByte}, 9'h040);
      xfer(2'h0, 1'b1, 1'b1, 8'h00);
      chk({1'b0, rspByte}, 9'h041);
      xfer(2'h3, 1'b1, 1'b1, 8'h00);
      chk({8'h00, rspError}, 9'h001);
      xfer(2'h2, 1'b1, 1'b0, 8'h00);
      chk({got[7:0], rspError}, 9'h02b);
      @(posedge clk) srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      #1;
      chk({7'h00, hard_reset_n, chipSelectN}, 9'h001);
      xfer(2'h1, 1'b1, 1'b1, 8'h00);
      chk({1'b0, rspByte}, 9'h040);
      stop_test;
   end
endmodule
bind dhi_host dhi_host_sva sva (.clk, .srst, .mode, .csLatch, .reqValid, .reqRead, .reqReady, .rspValid, .rspError,
   .chipSelectN, .cmdDataSelect, .strobeA, .strobeB, .busOut, .busOe);
`default_nettype wire
